//--- pcb_arbiter.sv
// round-robin bus arbiter with one-hot active-low grants
`default_nettype none
module pcb_arbiter
  import pcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [AGENTS-1:0] req_low_i,   // synchronised requests, active low
  input wire logic bus_idle_i,               // a held grant moves once its holder lets go; a grant from none only while idle
  output logic [AGENTS-1:0] gnt_low_o
);
  logic [AGENTS-1:0] gnt_ff;                 // one-hot, active high internally
  logic [AGENT_W-1:0] last_ff;               // last winner, fairness pointer
  logic [AGENTS-1:0] nxt_gnt;
  logic [AGENT_W-1:0] nxt_last;

  // pick first requester after last winner
  // the grant stays while its holder still asks for the bus, so a
  // start that is being launched never sees its grant taken away
  always_comb
  begin
    logic found;
    logic [AGENT_W-1:0] idx;
    found = 1'b0;
    idx = '0;
    nxt_gnt = gnt_ff;
    nxt_last = last_ff;
    if (((gnt_ff & ~req_low_i) == '0) && (bus_idle_i || (gnt_ff != '0)))
    begin
      nxt_gnt = '0;
      for (int k = 1; k <= AGENTS; k++)
      begin
        idx = AGENT_W'(last_ff + AGENT_W'(k));
        if (!found && !req_low_i[idx])
        begin
          found = 1'b1;
          nxt_gnt[idx] = 1'b1;                // single bit only
          nxt_last = idx;
        end
      end
    end
  end

  // grant state
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gnt_ff <= '0;
      last_ff <= AGENT_W'(AGENTS - 1);
    end
    else
    begin
      gnt_ff <= nxt_gnt;
      last_ff <= nxt_last;
    end
  end

  assign gnt_low_o = ~gnt_ff;                // active-low lines
endmodule
`default_nettype wire

//--- pcb_bridge_ports.sv
// link-side command filter, internal arbiter and system crossing of the bridge
`default_nettype none
// Operation
// - target claims io, mem, cfg, mrm, mrl, mwi
// - initiator issues no int-ack, special, mwi
// - ignore int-ack, special, reserved; never drive reserved
// - dual address only on 64-bit builds
// - one active-low grant per agent
// - arbiter ports exist only with internal arbiter; here they always exist, grants held high without it
// - main async low reset resets everything
// - optional extra reset spares the bridge
// - shared option uses one bus clock
// - independent option adds separate system clock
// - own request/grant wired to agent zero
module pcb_bridge_ports
  import pcb_pkg::*;
(
  input wire logic clk_i,                    // system clock
  input wire logic rst_b_i,                  // main reset, active low
  input wire logic sys_rst_b_i,              // optional system-only reset
  input wire logic link_clk_i,               // bus clock
  // target side: decoded address phase from the bus
  input wire logic tgt_frame_start_i,        // address phase strobe, link clock
  input wire logic [CMD_W-1:0] tgt_cmd_i,    // command on the bus
  output logic tgt_claim_o,                  // claim decision, link clock
  // initiator side: request from system logic
  input wire logic ini_valid_i,              // system-side request
  input wire pcb_req_s ini_req_i,
  output logic ini_ready_o,                  // crossing free
  output logic ini_reject_o,                 // command refused, pulse
  output logic ini_start_o,                  // link side starts a cycle
  output pcb_req_s ini_req_o,                // request as driven on the bus
  input wire logic ini_done_i,               // link cycle finished
  input wire logic bus_idle_i,               // no frame in progress
  output logic own_gnt_o,                    // bridge holds the bus
  output logic sys_rst_b_o,                  // reset for other system parts
  input wire logic [AGENTS-1:1] agent_bus_request_lines_low,
  output logic [AGENTS-1:1] agent_bus_grant_lines_low
);
  // legal to accept as target
  function automatic logic tgt_ok(input logic [CMD_W-1:0] c);
    case (pcb_cmd_e'(c))
      PCB_IO_RD, PCB_IO_WR, PCB_MEM_RD, PCB_MEM_WR, PCB_CFG_RD, PCB_CFG_WR,
      PCB_MEM_RD_MULT, PCB_MEM_RD_LINE, PCB_MEM_WR_INV: tgt_ok = 1'b1;
      PCB_DUAL_ADDR: tgt_ok = WIDE_BUS;
      default: tgt_ok = 1'b0;                // ack, special, reserved
    endcase
  endfunction

  // legal to issue as initiator
  function automatic logic ini_ok(input logic [CMD_W-1:0] c);
    case (pcb_cmd_e'(c))
      PCB_IO_RD, PCB_IO_WR, PCB_MEM_RD, PCB_MEM_WR, PCB_CFG_RD, PCB_CFG_WR,
      PCB_MEM_RD_MULT, PCB_MEM_RD_LINE: ini_ok = 1'b1;
      PCB_DUAL_ADDR: ini_ok = WIDE_BUS;
      default: ini_ok = 1'b0;                // never driven
    endcase
  endfunction

  // link clock: one clock in shared mode, two otherwise
  logic lclk;
  assign lclk = SPLIT_CLOCKS ? link_clk_i : clk_i;

  // system-side reset, bridge excluded
  assign sys_rst_b_o = SPLIT_RESET ? (rst_b_i & sys_rst_b_i) : rst_b_i;

  // target claim register, link clock
  always_ff @(posedge lclk or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tgt_claim_o <= 1'b0;
    else
      tgt_claim_o <= tgt_frame_start_i && tgt_ok(tgt_cmd_i);
  end

  // system side: toggle handshake launch
  // a toggle rather than a level: one edge per request survives any
  // ratio between the two clocks, at the cost of one request in flight
  logic req_tgl_ff;                          // flips per request
  logic ack_tgl_ff;                          // flips per finished request, link clock
  logic [2:0] ack_sync_ff;                   // ack toggle back from link
  pcb_req_s hold_ff;                         // request held stable across crossing
  logic busy;
  assign busy = req_tgl_ff != ack_sync_ff[2];
  assign ini_ready_o = !busy;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      req_tgl_ff <= 1'b0;
      hold_ff <= '0;
      ini_reject_o <= 1'b0;
    end
    else
    begin
      ini_reject_o <= ini_valid_i && !busy && !ini_ok(ini_req_i.cmd);
      if (ini_valid_i && !busy && ini_ok(ini_req_i.cmd))
      begin
        hold_ff <= ini_req_i;                // data stable until ack returns
        req_tgl_ff <= ~req_tgl_ff;
      end
    end
  end

  // ack synchroniser, third stage only compared
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ack_sync_ff <= '0;
    else
      ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
  end

  // link side: request synchroniser and bus request to agent zero
  logic [2:0] req_sync_ff;                   // stage 0 seen only by stage 1
  logic own_req_ff;                          // bridge wants the bus
  // hold_ff is sampled here only after the toggle has settled in two
  // agreeing stages, so the wide word needs no synchroniser of its own
  logic new_req;
  assign new_req = (req_sync_ff[2] == req_sync_ff[1]) && (req_sync_ff[2] != ack_tgl_ff);

  always_ff @(posedge lclk or negedge rst_b_i)
  begin
    if (!rst_b_i)
      req_sync_ff <= '0;
    else
      req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
  end

  // link-side request ownership
  always_ff @(posedge lclk or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      own_req_ff <= 1'b0;
      ack_tgl_ff <= 1'b0;
      ini_start_o <= 1'b0;
      ini_req_o <= '0;
    end
    else
    begin
      ini_start_o <= 1'b0;
      if (new_req && !own_req_ff)
      begin
        own_req_ff <= 1'b1;
        ini_req_o <= hold_ff;                // stable for many cycles by handshake
      end
      else if (own_req_ff && own_gnt_o && bus_idle_i && !ini_start_o)
        ini_start_o <= 1'b1;
      if (own_req_ff && ini_done_i)
      begin
        own_req_ff <= 1'b0;
        ack_tgl_ff <= ~ack_tgl_ff;           // releases system side
      end
    end
  end

  // agent request synchronisers, 3 stages, agreement of 2 and 3
  // a request shorter than two link cycles is filtered out: agents
  // must hold a change at least that long for the arbiter to see it
  logic [AGENTS-1:0] areq_low;
  logic [AGENTS-1:0] gnt_low;
  assign areq_low[OWN_AGENT] = !own_req_ff;

  generate
    for (genvar a = 1; a < AGENTS; a++)
    begin : g_sync
      logic [2:0] sync_ff;                   // raw pin stages, idle high
      logic filt_ff;                         // settled level
      always_ff @(posedge lclk or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          sync_ff <= 3'h7;
          filt_ff <= 1'b1;
        end
        else
        begin
          sync_ff <= {sync_ff[1:0], agent_bus_request_lines_low[a]};
          if (sync_ff[2] == sync_ff[1])
            filt_ff <= sync_ff[2];
        end
      end
      assign areq_low[a] = filt_ff;
    end
  endgenerate

  generate
    if (INTERNAL_ARB)
    begin : g_arb
      pcb_arbiter u_arb (
        .clk_i(lclk),
        .rst_b_i(rst_b_i),
        .req_low_i(areq_low),
        .bus_idle_i(bus_idle_i),
        .gnt_low_o(gnt_low)
      );
    end
    else
    begin : g_no_arb
      // external arbiter: own grant assumed, agent lines inert
      assign gnt_low = ~(AGENTS'(1) << OWN_AGENT);
    end
  endgenerate

  // own grant read straight from the arbiter flop, no extra delay
  assign own_gnt_o = !gnt_low[OWN_AGENT];
  assign agent_bus_grant_lines_low = INTERNAL_ARB ? gnt_low[AGENTS-1:1]
                                                  : GNT_IDLE_LOW[AGENTS-1:1];
endmodule
`default_nettype wire

//--- pcb_bridge_ports_properties.sv
// checker for command filtering, grants and resets of the bridge ports
`default_nettype none
module pcb_bridge_ports_properties
  import pcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sys_rst_b_i,
  input wire logic link_clk_i,
  input wire logic tgt_frame_start_i,
  input wire logic [CMD_W-1:0] tgt_cmd_i,
  input wire logic tgt_claim_o,
  input wire logic ini_valid_i,
  input wire pcb_req_s ini_req_i,
  input wire logic ini_ready_o,
  input wire logic ini_reject_o,
  input wire logic ini_start_o,
  input wire pcb_req_s ini_req_o,
  input wire logic own_gnt_o,
  input wire logic sys_rst_b_o,
  input wire logic [AGENTS-1:1] agent_bus_grant_lines_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // legal command masks by code; dual address only on wide builds
  localparam logic [15:0] TGT_OK = 16'hdccc | (WIDE_BUS ? 16'h2000 : 16'h0000);
  localparam logic [15:0] INI_OK = 16'h5ccc | (WIDE_BUS ? 16'h2000 : 16'h0000);
  // request taken on the system side
  sequence s_take;
    ini_valid_i && ini_ready_o;
  endsequence
  // address phase of a command the target must leave alone
  sequence s_tgt_bad;
    tgt_frame_start_i && !TGT_OK[tgt_cmd_i];
  endsequence
  chk_claim_legal: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    tgt_frame_start_i && TGT_OK[tgt_cmd_i] |=> tgt_claim_o) else $error("legal cmd unclaimed");
  chk_claim_ignored: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    s_tgt_bad |=> !tgt_claim_o) else $error("illegal cmd claimed");
  chk_reject_bad: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_take ##0 !INI_OK[ini_req_i.cmd] |=> ini_reject_o) else $error("bad cmd not refused");
  chk_take_good: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_take ##0 INI_OK[ini_req_i.cmd] |=> !ini_reject_o && !ini_ready_o) else $error("take wrong");
  chk_start_cmd: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    ini_start_o |-> INI_OK[ini_req_o.cmd]) else $error("illegal cmd started");
  chk_start_owned: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    ini_start_o |-> own_gnt_o) else $error("start without grant");
  chk_one_grant: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $onehot0({~agent_bus_grant_lines_low, own_gnt_o})) else $error("two grants");
  chk_sys_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sys_rst_b_o == sys_rst_b_i) else $error("system reset wrong");
  chk_reset_quiet: assert property (@(posedge clk_i)
    !rst_b_i |-> agent_bus_grant_lines_low == 3'h7 && !ini_reject_o && ini_ready_o)
    else $error("reset state wrong");
endmodule
bind pcb_bridge_ports pcb_bridge_ports_properties u_props (.*);
`default_nettype wire

//--- pcb_bridge_ports_test.sv
// self-checking bench for the bridge ports
`default_nettype none
module pcb_bridge_ports_test
  import pcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, link_clk_i = 0, rst_b_i = 0, sys_rst_b_i = 0, slow = 0;
  logic tgt_frame_start_i = 0, ini_valid_i = 0, tgt_claim_o, ini_ready_o, ini_reject_o;
  logic ini_start_o, ini_done_i, bus_idle_i, own_gnt_o, sys_rst_b_o;
  logic [CMD_W-1:0] tgt_cmd_i = 4'h0;
  pcb_req_s ini_req_i = '0;
  pcb_req_s ini_req_o;
  logic [AGENTS-1:1] want = 3'h0, agent_bus_request_lines_low, agent_bus_grant_lines_low;
  int num_errors = 0, compares = 0, n;
  logic [5:0] r;
  // rows: command, claim as target, refusal as initiator
  logic [5:0] rows [16] = '{6'h01, 6'h05, 6'h0a, 6'h0e, 6'h11, 6'h15, 6'h1a, 6'h1e,
    6'h21, 6'h25, 6'h2a, 6'h2e, 6'h32, 6'h35, 6'h3a, 6'h3f};
  pcb_bridge_ports u_dut (.*);
  pcb_bus_agents u_far (.link_clk_i(link_clk_i), .rst_b_i(rst_b_i), .want_i(want),
    .slow_i(slow), .start_i(ini_start_o), .gnt_low_i(agent_bus_grant_lines_low),
    .req_low_o(agent_bus_request_lines_low), .done_o(ini_done_i), .idle_o(bus_idle_i));
  // two unrelated clocks, bus clock separate from system clock
  initial forever #25 clk_i = ~clk_i;
  initial
  begin
    #7;
    forever #16 link_clk_i = ~link_clk_i;
  end
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial
  begin
    #3_000_000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    sys_rst_b_i <= 1'b1;
    want <= 3'h7;
    for (int i = 0; i < 16; i++)
    begin
      r = rows[i];
      slow <= i[0];
      @(posedge link_clk_i);
      tgt_frame_start_i <= 1'b1;
      tgt_cmd_i <= r[5:2];
      @(posedge link_clk_i);
      tgt_frame_start_i <= 1'b0;
      @(negedge link_clk_i);
      check(tgt_claim_o, r[1]);
      for (n = 0; n < 400 && ini_ready_o !== 1'b1; n++) @(negedge clk_i);
      @(posedge clk_i);
      ini_valid_i <= 1'b1;
      ini_req_i <= {r[5:2], {8{r[5:2]}}};
      @(posedge clk_i);
      ini_valid_i <= 1'b0;
      @(negedge clk_i);
      check(ini_reject_o, r[0]);
      for (n = 0; n < 400 && !r[0] && ini_start_o !== 1'b1; n++) @(negedge link_clk_i);
      if (!r[0])
        check({ini_start_o, ini_req_o}, {1'b1, r[5:2], {8{r[5:2]}}});
      $display("row %0d done", i);
    end
    // lone agent request must win the bus
    want <= 3'b010;
    for (n = 0; n < 200 && agent_bus_grant_lines_low !== 3'b101; n++) @(negedge link_clk_i);
    check(agent_bus_grant_lines_low, 3'b101);
    want <= 3'h0;
    // back-to-back address phases, claimed then ignored
    @(posedge link_clk_i);
    tgt_frame_start_i <= 1'b1;
    tgt_cmd_i <= 4'hf;
    @(posedge link_clk_i);
    tgt_cmd_i <= 4'h0;
    @(negedge link_clk_i);
    check(tgt_claim_o, 1'b1);
    @(posedge link_clk_i);
    tgt_frame_start_i <= 1'b0;
    @(negedge link_clk_i);
    check(tgt_claim_o, 1'b0);
    $display("target pair done");
    // system-only reset spares the bridge
    @(posedge clk_i);
    sys_rst_b_i <= 1'b0;
    @(negedge clk_i);
    check({sys_rst_b_o, ini_ready_o}, 2'b01);
    sys_rst_b_i <= 1'b1;
    // main reset in mid-run quiets everything
    want <= 3'h7;
    repeat (6) @(posedge link_clk_i);
    rst_b_i <= 1'b0;
    @(negedge link_clk_i);
    check({agent_bus_grant_lines_low, tgt_claim_o, ini_ready_o, sys_rst_b_o}, 6'h3a);
    $display("reset tests done");
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- pcb_bus_agents.sv
// far side of the bus: other masters and the terminator of the bridge's cycles
`default_nettype none
module pcb_bus_agents
  import pcb_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  input wire logic [AGENTS-1:1] want_i, // agents wishing to own the bus
  input wire logic slow_i,              // stretch the bridge's cycle
  input wire logic start_i,
  input wire logic [AGENTS-1:1] gnt_low_i,
  output logic [AGENTS-1:1] req_low_o,
  output logic done_o,
  output logic idle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] own_ff; // bridge cycle left
  logic [2:0] ag_ff;  // agent frame left
  // bridge cycle ends after a short or a long stretch
  always_ff @(posedge link_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      own_ff <= 4'h0;
    else if (start_i)
      own_ff <= slow_i ? 4'h9 : 4'h2;
    else if (own_ff != 4'h0)
      own_ff <= own_ff - 4'h1;
  end
  // granted agent runs a four-cycle frame, only on a free bus
  always_ff @(posedge link_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ag_ff <= 3'h0;
    else if (ag_ff != 3'h0)
      ag_ff <= ag_ff - 3'h1;
    else if (idle_o && (~gnt_low_i & want_i) != 3'h0)
      ag_ff <= 3'h4;
  end
  assign done_o = own_ff == 4'h1;
  assign idle_o = own_ff == 4'h0 && ag_ff == 3'h0 && !start_i;
  // request low while wanted, let go for the whole frame so the drop
  // outlasts the bridge's pin filter and the grant can rotate
  assign req_low_o = ~want_i | ((ag_ff != 3'h0) ? ~gnt_low_i : 3'h0);
endmodule
`default_nettype wire

//--- pcb_pkg.sv
// package for the bus command filter, arbiter and clock crossing of the bridge
`default_nettype none
package pcb_pkg;
  localparam int unsigned CMD_W = 4;              // command/byte-enable field width
  localparam int unsigned AGENTS = 4;             // arbiter channels, agent zero is ours
  localparam int unsigned AGENT_W = 2;            // agent index width
  localparam int unsigned OWN_AGENT = 0;          // bridge's own channel
  localparam int unsigned DATA_W = 32;            // system word width
  localparam bit WIDE_BUS = 1'b0;                 // 64-bit build enables dual address
  localparam bit INTERNAL_ARB = 1'b1;             // arbiter built into the device
  localparam bit SPLIT_CLOCKS = 1'b1;             // independent link and system clocks
  localparam bit SPLIT_RESET = 1'b1;              // extra system-side reset provided
  localparam logic [AGENTS-1:0] GNT_IDLE_LOW = 4'hf; // no grant, all lines high

  // bus command encodings
  typedef enum logic [CMD_W-1:0] {
    PCB_INT_ACK = 4'h0,
    PCB_SPECIAL = 4'h1,
    PCB_IO_RD = 4'h2,
    PCB_IO_WR = 4'h3,
    PCB_RSV4 = 4'h4,
    PCB_RSV5 = 4'h5,
    PCB_MEM_RD = 4'h6,
    PCB_MEM_WR = 4'h7,
    PCB_RSV8 = 4'h8,
    PCB_RSV9 = 4'h9,
    PCB_CFG_RD = 4'ha,
    PCB_CFG_WR = 4'hb,
    PCB_MEM_RD_MULT = 4'hc,
    PCB_DUAL_ADDR = 4'hd,
    PCB_MEM_RD_LINE = 4'he,
    PCB_MEM_WR_INV = 4'hf
  } pcb_cmd_e;

  // one initiator request carried from system side to link side
  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic [DATA_W-1:0] addr;
  } pcb_req_s;
endpackage
`default_nettype wire
